// ===== design/nbr_pkg.sv
package nbr_pkg;

  // ****************************************
  // register map (byte offsets)
  // ****************************************
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STAT_OFFSET = 8'h04;
  localparam logic [7:0] DATA_OFFSET = 8'h08;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_NINE_BIT = 0;
  localparam int CTRL_DETECT_BIT = 1;
  localparam int STAT_PEND_BIT = 0;
  localparam int STAT_NINTH_BIT = 1;
  localparam int STAT_FERR_BIT = 2;
  localparam int STAT_OERR_BIT = 3;

  // ****************************************
  // reset values and sizes
  // ****************************************
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int QUEUE_DEPTH = 2;
  localparam int FIFO_DEPTH_DEFAULT = 16;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int BIT_TIME_NS = 8680;
  localparam int CLKS_PER_BIT = BIT_TIME_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic ferr;
    logic ninth_data_bit;
    logic [7:0] data;
  } nbr_char_s;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } nbr_rx_state_e;

endpackage : nbr_pkg

// ===== design/nbr_rx.sv
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps

// ****************************************
// receive queue
// ****************************************
module nbr_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = nbr_pkg::FIFO_DEPTH_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH+1)-1:0] level_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LW = $clog2(DEPTH + 1);
  localparam logic [LW-1:0] FULL_LEVEL = LW'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [LW-1:0] level, next_level;
  logic push, pop;
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : ptr_inc
  assign in_ready_o = (level != FULL_LEVEL);
  assign out_valid_o = (level != '0);
  assign out_data_o = mem[rd_ptr];
  assign level_o = level;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_comb begin
    next_wr_ptr = push ? ptr_inc(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? ptr_inc(rd_ptr) : rd_ptr;
    next_level = level + LW'(push) - LW'(pop);
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level <= next_level;
    end
  end
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule : nbr_fifo

// Functional notes
// - nine-bit enable shifts nine bits per character
// - ninth bit status shows oldest unread character
// - address detect enable bit turns mode on
// - address detection needs nine-bit reception enabled
// - address mode stores only ninth-bit-set characters
// - pending flag high while queue holds characters
// - queue holds two characters with ninth, ferr
module nbr_rx #(
  parameter int CLKS_PER_BIT = nbr_pkg::CLKS_PER_BIT,
  parameter int QUEUE_DEPTH = nbr_pkg::QUEUE_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic rx_i,
  output logic receive_pending_flag_o
);
  localparam int CW = 16;
  localparam logic [CW-1:0] FULL_CNT = CW'(CLKS_PER_BIT - 1);
  localparam logic [CW-1:0] HALF_CNT = CW'(CLKS_PER_BIT / 2);
  localparam int LW = $clog2(QUEUE_DEPTH + 1);
  // ****************************************
  // pin synchroniser
  // ****************************************
  logic rx_meta, rx_s;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_meta <= 1'b1;
      rx_s <= 1'b1;
    end else begin
      rx_meta <= rx_i;
      rx_s <= rx_meta;
    end
  end
  // ****************************************
  // registers and bus
  // ****************************************
  logic nine_bit_receive_enable, address_detect_enable, overrun;
  logic next_nine_en, next_addr_en, next_overrun, next_ack, next_pend;
  logic [31:0] next_dat;
  logic req, rd_data, wr_ctrl, clr_ovr, ovr_set;
  nbr_pkg::nbr_char_s q_in, q_out;
  logic q_push, q_in_ready, q_valid;
  logic [LW-1:0] q_level;
  assign req = cyc_i && stb_i && !ack_o;
  assign wr_ctrl = req && we_i && sel_i[0] && adr_i == nbr_pkg::CTRL_OFFSET;
  assign clr_ovr = req && we_i && sel_i[0] && adr_i == nbr_pkg::STAT_OFFSET
    && dat_i[nbr_pkg::STAT_OERR_BIT];
  // reading the data word advances the queue
  assign rd_data = req && !we_i && adr_i == nbr_pkg::DATA_OFFSET;
  always_comb begin
    next_nine_en = nine_bit_receive_enable;
    next_addr_en = address_detect_enable;
    if (wr_ctrl) begin
      next_nine_en = dat_i[nbr_pkg::CTRL_NINE_BIT];
      next_addr_en = dat_i[nbr_pkg::CTRL_DETECT_BIT];
    end
    // a new overrun beats a clear in the same cycle
    next_overrun = ovr_set || (overrun && !clr_ovr);
    next_ack = req;
    next_dat = '0;
    if (req && !we_i) begin
      case (adr_i)
        nbr_pkg::CTRL_OFFSET: begin
          next_dat[nbr_pkg::CTRL_NINE_BIT] = nine_bit_receive_enable;
          next_dat[nbr_pkg::CTRL_DETECT_BIT] = address_detect_enable;
        end
        nbr_pkg::STAT_OFFSET: begin
          next_dat[nbr_pkg::STAT_PEND_BIT] = q_valid;
          next_dat[nbr_pkg::STAT_NINTH_BIT] = q_valid
            && q_out.ninth_data_bit;
          next_dat[nbr_pkg::STAT_FERR_BIT] = q_valid && q_out.ferr;
          next_dat[nbr_pkg::STAT_OERR_BIT] = overrun;
        end
        nbr_pkg::DATA_OFFSET: next_dat[7:0] = q_valid ? q_out.data : 8'h00;
        default: next_dat = '0;
      endcase
    end
    next_pend = q_valid;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nine_bit_receive_enable <= nbr_pkg::CTRL_RESET[nbr_pkg::CTRL_NINE_BIT];
      address_detect_enable <= nbr_pkg::CTRL_RESET[nbr_pkg::CTRL_DETECT_BIT];
      overrun <= 1'b0;
      ack_o <= 1'b0;
      dat_o <= '0;
      receive_pending_flag_o <= 1'b0;
    end else begin
      nine_bit_receive_enable <= next_nine_en;
      address_detect_enable <= next_addr_en;
      overrun <= next_overrun;
      ack_o <= next_ack;
      dat_o <= next_dat;
      receive_pending_flag_o <= next_pend;
    end
  end
  // ****************************************
  // receive shifter
  // ****************************************
  nbr_pkg::nbr_rx_state_e state, next_state;
  logic [CW-1:0] cnt, next_cnt;
  logic [3:0] idx, next_idx;
  logic [8:0] receive_shift_register, next_shift;
  logic frame_done, stop_ok, keep;
  always_comb begin
    next_state = state;
    next_cnt = (cnt == '0) ? cnt : cnt - CW'(1);
    next_idx = idx;
    next_shift = receive_shift_register;
    frame_done = 1'b0;
    case (state)
      nbr_pkg::RX_IDLE: begin
        if (!rx_s) begin
          next_state = nbr_pkg::RX_START;
          next_cnt = HALF_CNT;
        end
      end
      nbr_pkg::RX_START: begin
        if (cnt == '0) begin
          next_state = rx_s ? nbr_pkg::RX_IDLE : nbr_pkg::RX_DATA;
          next_cnt = FULL_CNT;
          next_idx = '0;
          next_shift = '0;
        end
      end
      nbr_pkg::RX_DATA: begin
        if (cnt == '0) begin
          next_shift[idx] = rx_s;
          next_idx = idx + 4'h1;
          next_cnt = FULL_CNT;
          // nine data bits when enabled, else eight
          if (idx == (nine_bit_receive_enable ? 4'h8 : 4'h7)) begin
            next_state = nbr_pkg::RX_STOP;
          end
        end
      end
      nbr_pkg::RX_STOP: begin
        if (cnt == '0) begin
          frame_done = 1'b1;
          next_state = nbr_pkg::RX_IDLE;
        end
      end
      default: next_state = nbr_pkg::RX_IDLE;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= nbr_pkg::RX_IDLE;
      cnt <= '0;
      idx <= '0;
      receive_shift_register <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      idx <= next_idx;
      receive_shift_register <= next_shift;
    end
  end
  // ****************************************
  // queue entry
  // ****************************************
  // address mode relies on software also enabling nine-bit frames
  assign keep = !address_detect_enable
    || receive_shift_register[8];
  assign stop_ok = rx_s;
  // while overrun stands, whole frames are dropped
  assign q_push = frame_done && keep && !overrun && q_in_ready;
  assign ovr_set = frame_done && keep && !overrun && !q_in_ready;
  always_comb begin
    q_in.data = receive_shift_register[7:0];
    q_in.ninth_data_bit = nine_bit_receive_enable
      && receive_shift_register[8];
    q_in.ferr = !stop_ok;
  end
  nbr_fifo #(
    .WIDTH($bits(nbr_pkg::nbr_char_s)),
    .DEPTH(QUEUE_DEPTH)
  ) u_queue (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(q_push),
    .in_ready_o(q_in_ready),
    .in_data_i(q_in),
    .out_valid_o(q_valid),
    .out_ready_i(rd_data),
    .out_data_o(q_out),
    .level_o(q_level)
  );
  // ****************************************
  // checks
  // ****************************************
  a_pending_flag: assert property (@(posedge clk_i)
    disable iff (rst_i) 1'b1 |=> receive_pending_flag_o == $past(q_valid))
    else $error("pending flag does not follow queue state");
  a_addr_discard: assert property (@(posedge clk_i)
    disable iff (rst_i) frame_done && address_detect_enable
    && !receive_shift_register[8] |-> !q_push)
    else $error("non-address character stored in address mode");
  a_addr_accept: assert property (@(posedge clk_i)
    disable iff (rst_i) frame_done && address_detect_enable
    && receive_shift_register[8] && q_in_ready && !overrun |=> q_valid)
    else $error("address character not stored");
  a_nine_store: assert property (@(posedge clk_i)
    disable iff (rst_i) frame_done && nine_bit_receive_enable
    && !address_detect_enable && q_in_ready && !overrun
    |-> q_push && q_in.ninth_data_bit == receive_shift_register[8])
    else $error("nine-bit character lost or ninth bit wrong");
  a_bit_count: assert property (@(posedge clk_i)
    disable iff (rst_i) state == nbr_pkg::RX_DATA
    |-> idx <= (nine_bit_receive_enable ? 4'h8 : 4'h7))
    else $error("too many data bits shifted");
  a_queue_cap: assert property (@(posedge clk_i)
    disable iff (rst_i) !q_in_ready |-> q_level == LW'(QUEUE_DEPTH))
    else $error("queue refused entry before holding two");
  a_ninth_head: assert property (@(posedge clk_i)
    disable iff (rst_i) req && !we_i && adr_i == nbr_pkg::STAT_OFFSET
    && q_valid |=> dat_o[nbr_pkg::STAT_NINTH_BIT]
    == $past(q_out.ninth_data_bit))
    else $error("ninth bit status not from oldest character");
  a_detect_ctrl: assert property (@(posedge clk_i)
    disable iff (rst_i) wr_ctrl |=> address_detect_enable
    == $past(dat_i[nbr_pkg::CTRL_DETECT_BIT]))
    else $error("address detect enable not taken");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
endmodule : nbr_rx

// ===== dv/nbr_line_model.sv
`timescale 1ns/1ps

// ****************************************
// remote transmitter on the shared line
// ****************************************
module nbr_line_model #(
  parameter int CLKS_PER_BIT = 8
) (
  input wire logic clk_i,
  output logic rx_o
);
  initial rx_o = 1'b1;

  task automatic send(input logic [8:0] d, input int n, input logic stop);
    @(posedge clk_i);
    rx_o <= 1'b0;
    repeat (CLKS_PER_BIT) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      rx_o <= d[i];
      repeat (CLKS_PER_BIT) @(posedge clk_i);
    end
    rx_o <= stop;
    repeat (CLKS_PER_BIT) @(posedge clk_i);
    // line idles high between frames
    rx_o <= 1'b1;
    repeat (CLKS_PER_BIT) @(posedge clk_i);
  endtask : send
endmodule : nbr_line_model

// ===== dv/tb.sv
`timescale 1ns/1ps

module tb;
  localparam int CPB = 8;
  localparam logic [7:0] CT = nbr_pkg::CTRL_OFFSET;
  localparam logic [7:0] ST = nbr_pkg::STAT_OFFSET;
  localparam logic [7:0] DT = nbr_pkg::DATA_OFFSET;
  localparam logic [31:0] R9 = 32'h1 << nbr_pkg::CTRL_NINE_BIT;
  localparam logic [31:0] AD = 32'h1 << nbr_pkg::CTRL_DETECT_BIT;
  localparam logic [31:0] PE = 32'h1 << nbr_pkg::STAT_PEND_BIT;
  localparam logic [31:0] NI = 32'h1 << nbr_pkg::STAT_NINTH_BIT;
  localparam logic [31:0] FE = 32'h1 << nbr_pkg::STAT_FERR_BIT;
  localparam logic [31:0] OV = 32'h1 << nbr_pkg::STAT_OERR_BIT;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic rx_i;
  logic receive_pending_flag_o;
  int failures = 0;
  int compares = 0;

  always #50 clk_i = ~clk_i;

  nbr_rx #(.CLKS_PER_BIT(CPB)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .rx_i(rx_i), .receive_pending_flag_o(receive_pending_flag_o));
  nbr_line_model #(.CLKS_PER_BIT(CPB)) u_tx (.clk_i(clk_i), .rx_o(rx_i));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic finish_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  // waits past the stop bit so the character has landed
  task automatic frame(input logic [8:0] d, input int n, input logic s);
    u_tx.send(d, n, s);
    repeat (CPB) @(posedge clk_i);
  endtask : frame

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rd(CT, 32'h0);
    rd(ST, 32'h0);
    wr(8'h0c, 32'hffffffff);
    rd(8'h0c, 32'h0);
    chk({31'h0, receive_pending_flag_o}, 32'h0);
  endtask : t_reset

  task automatic t_eight;
    frame(9'h1a5, 8, 1'b1);
    chk({31'h0, receive_pending_flag_o}, 32'h1);
    rd(ST, PE);
    rd(DT, 32'h0a5);
    rd(ST, 32'h0);
    chk({31'h0, receive_pending_flag_o}, 32'h0);
  endtask : t_eight

  task automatic t_nine;
    wr(CT, R9);
    rd(CT, R9);
    frame(9'h13c, 9, 1'b1);
    frame(9'h0c3, 9, 1'b0);
    frame(9'h155, 9, 1'b1);
    rd(ST, PE | NI | OV);
    rd(DT, 32'h03c);
    rd(ST, PE | FE | OV);
    rd(DT, 32'h0c3);
    rd(ST, OV);
    wr(ST, OV);
    rd(ST, 32'h0);
  endtask : t_nine

  task automatic t_addr;
    wr(CT, AD);
    frame(9'h066, 8, 1'b1);
    rd(ST, 32'h0);
    wr(CT, R9 | AD);
    frame(9'h011, 9, 1'b1);
    rd(ST, 32'h0);
    chk({31'h0, receive_pending_flag_o}, 32'h0);
    frame(9'h122, 9, 1'b1);
    rd(ST, PE | NI);
    rd(DT, 32'h022);
    wr(CT, R9);
    frame(9'h033, 9, 1'b1);
    rd(ST, PE);
    rd(DT, 32'h033);
    wr(CT, R9 | AD);
    frame(9'h044, 9, 1'b1);
    rd(ST, 32'h0);
  endtask : t_addr

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_eight();
    t_nine();
    t_addr();
    finish_test();
  end

  initial begin
    repeat (6000) @(posedge clk_i);
    failures++;
    finish_test();
  end
endmodule : tb
